// ### verilog/i2cas_pkg.sv
// Constants shared by the I2C target address-select block
package i2cas_pkg;
  localparam int CLK_MHZ = 200;
  // Fixed target address bits, straps read as zero here
  localparam logic [6:0] TGT_ADDR_BASE = 7'h27;
  localparam int STRAP_HI_POS = 4;
  localparam int STRAP_LO_POS = 3;
  // Boot delay before the target answers
  localparam int T_BOOT_NS = 1000;
  localparam int BOOT_CYC = (T_BOOT_NS * CLK_MHZ + 999) / 1000;
  localparam int BOOT_W = 8;
  // Spike filter on SCL and SDA, a longest time, so rounded down
  localparam int T_SPIKE_NS = 50;
  localparam int SPIKE_CYC = (T_SPIKE_NS * CLK_MHZ) / 1000;
  localparam int FILT_W = 4;
  // Cycles from pointer update to loaded transmit byte
  localparam logic [1:0] LOAD_CYC = 2'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int MEM_AW = 8;
  localparam int MEM_DW = 8;
  localparam int IRQ_W = 8;
endpackage : i2cas_pkg

// ### verilog/i2cas_mem.sv
// Sub-address byte store with registered read data
`timescale 1ns/1ps
`default_nettype none
module i2cas_mem import i2cas_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Write port
  input wire logic wr_en,
  input wire logic [MEM_AW-1:0] wr_addr,
  input wire logic [MEM_DW-1:0] wr_data,
  // Read port
  input wire logic [MEM_AW-1:0] rd_addr,
  output logic [MEM_DW-1:0] rd_data
);
  logic [MEM_DW-1:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : i2cas_mem
`default_nettype wire

// ### verilog/i2cas_target.sv
// I2C target with strap-selected address, sub-address access and interrupt
// How it works
// - No answer before boot sets the address
// - Match 0,1,strap high,strap low,1,1,1 plus direction
// - Straps sampled as plain high or low levels
// - First written byte is the sub-address
// - Acknowledge matching address and every received byte
// - Hold SCL low after a byte until ready
// - Standard and Fast mode rates supported
// - Interrupt low only for unmasked events
`timescale 1ns/1ps
`default_nettype none
module i2cas_target import i2cas_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Address straps
  input wire logic addr_strap_low_bit,
  input wire logic addr_strap_high_bit,
  // I2C pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Core side
  input wire logic core_busy,
  input wire logic core_wr_en,
  input wire logic [MEM_AW-1:0] core_addr,
  input wire logic [MEM_DW-1:0] core_wdata,
  output logic cmd_valid,
  output logic [MEM_AW-1:0] cmd_addr,
  output logic [MEM_DW-1:0] cmd_data,
  output logic addr_ready,
  // Interrupt
  input wire logic [IRQ_W-1:0] irq_event,
  input wire logic [IRQ_W-1:0] irq_mask,
  input wire logic [IRQ_W-1:0] irq_clear,
  output logic host_interrupt_n
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_RDATA, ST_MACK, ST_SKIP}
    i2cas_state_e;

  i2cas_state_e state;
  logic [BOOT_W-1:0] boot_cnt;
  logic strap_hi;
  logic strap_lo;
  logic [1:0] pin_raw;
  logic [1:0] pin_flt;
  logic scl_q;
  logic sda_q;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic ack_phase;
  logic [MEM_AW-1:0] ptr;
  logic [1:0] load_cnt;
  logic i2c_wr;
  logic [IRQ_W-1:0] pend;
  logic [MEM_DW-1:0] mem_rdata;
  // Glitch filter: a level passes only after it held for the spike window
  assign pin_raw = {sda_in, scl_in};
  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic [FILT_W-1:0] cnt;
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        cnt <= 4'h0;
        pin_flt[i] <= 1'b1;
      end else if (pin_raw[i] == pin_flt[i]) begin
        cnt <= 4'h0;
      end else if (cnt == FILT_W'(SPIKE_CYC - 1)) begin
        cnt <= 4'h0;
        pin_flt[i] <= pin_raw[i];
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  wire scl_f = pin_flt[0];
  wire sda_f = pin_flt[1];
  wire scl_rise = scl_f && !scl_q;
  wire scl_fall = !scl_f && scl_q;
  wire bus_start = scl_f && scl_q && sda_q && !sda_f;
  wire bus_stop = scl_f && scl_q && !sda_q && sda_f;
  wire boot_done = boot_cnt == BOOT_W'(BOOT_CYC - 1);
  wire [6:0] my_addr = {TGT_ADDR_BASE[6:5], strap_hi, strap_lo, TGT_ADDR_BASE[2:0]};
  wire addr_match = shreg[7:1] == my_addr;
  wire rx_state = state == ST_ADDR || state == ST_SUB || state == ST_WDATA;
  wire rx_bit = rx_state && scl_rise && !ack_phase;
  wire rx_done = rx_state && scl_fall && !ack_phase && bitcnt == BYTE_BITS;
  wire ack_end = rx_state && scl_fall && ack_phase;
  wire byte_end = ack_end || (state == ST_MACK && scl_fall);
  wire tx_load = state == ST_RDATA && load_cnt == 2'h1;
  wire [MEM_AW-1:0] mem_waddr = i2c_wr ? cmd_addr : core_addr;
  wire [IRQ_W-1:0] next_pend = (pend & ~irq_clear) | irq_event;
  // Boot counter, then straps caught once after reset release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot_cnt <= '0;
      addr_ready <= 1'b0;
    end else if (!addr_ready) begin
      boot_cnt <= boot_cnt + 8'h01;
      addr_ready <= boot_done;
    end
  end
  // Clocked capture keeps strap pins out of the reset branch
  always_ff @(posedge mclk) begin
    if (!addr_ready && boot_done) begin
      strap_hi <= addr_strap_high_bit;
      strap_lo <= addr_strap_low_bit;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end
  // Protocol engine
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ack_phase <= 1'b0;
      ptr <= 8'h00;
      load_cnt <= 2'h0;
      sda_oe <= 1'b0;
      i2c_wr <= 1'b0;
    end else begin
      i2c_wr <= 1'b0;
      if (bus_stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        load_cnt <= 2'h0;
      end else if (bus_start && addr_ready) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
        load_cnt <= 2'h0;
      end else if (rx_bit) begin
        shreg <= {shreg[6:0], sda_f};
        bitcnt <= bitcnt + 4'h1;
      end else if (rx_done) begin
        bitcnt <= 4'h0;
        if (state == ST_ADDR && !addr_match) begin
          state <= ST_SKIP;
        end else begin
          ack_phase <= 1'b1;
          sda_oe <= 1'b1;
          i2c_wr <= state == ST_WDATA;
        end
      end else if (ack_end) begin
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
        case (state)
          ST_ADDR: begin
            if (shreg[0]) begin
              state <= ST_RDATA;
              load_cnt <= LOAD_CYC;
            end else begin
              state <= ST_SUB;
            end
          end
          ST_SUB: begin
            ptr <= shreg;
            state <= ST_WDATA;
          end
          default: begin
            ptr <= ptr + 8'h01;
          end
        endcase
      end else begin
        case (state)
          ST_RDATA: begin
            if (load_cnt != 2'h0) begin
              load_cnt <= load_cnt - 2'h1;
            end
            if (tx_load) begin
              shreg <= mem_rdata;
              sda_oe <= !mem_rdata[7];
              bitcnt <= 4'h1;
            end else if (scl_fall && load_cnt == 2'h0) begin
              if (bitcnt == BYTE_BITS) begin
                sda_oe <= 1'b0;
                state <= ST_MACK;
              end else begin
                sda_oe <= !shreg[6];
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            // A controller NACK ends the read; only a stop or start follows
            if (scl_rise && sda_f) begin
              state <= ST_SKIP;
            end else if (scl_fall) begin
              ptr <= ptr + 8'h01;
              load_cnt <= LOAD_CYC;
              state <= ST_RDATA;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  // Clock stretch after each acknowledged byte while the core or the read fetch is busy
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_oe <= 1'b0;
    end else if (byte_end) begin
      scl_oe <= 1'b1;
    end else if (!core_busy && load_cnt == 2'h0) begin
      scl_oe <= 1'b0;
    end
  end
  // Written bytes go to the store and to the core as one-cycle commands
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_valid <= 1'b0;
      cmd_addr <= 8'h00;
      cmd_data <= 8'h00;
    end else begin
      cmd_valid <= rx_done && state == ST_WDATA;
      if (rx_done && state == ST_WDATA) begin
        cmd_addr <= ptr;
        cmd_data <= shreg;
      end
    end
  end
  // Sticky events, set wins over clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend <= 8'h00;
      host_interrupt_n <= 1'b1;
    end else begin
      pend <= next_pend;
      host_interrupt_n <= !(|(next_pend & irq_mask));
    end
  end
  // Bus writes win the store port; a core write in that cycle is dropped
  i2cas_mem u_mem (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(i2c_wr || core_wr_en),
    .wr_addr(mem_waddr),
    .wr_data(i2c_wr ? cmd_data : core_wdata),
    .rd_addr(ptr),
    .rd_data(mem_rdata)
  );
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_byte_end;
    byte_end ##1 scl_oe;
  endsequence
  sequence s_fetch;
    load_cnt == 2'h2 ##1 load_cnt == 2'h1;
  endsequence

  chk_quiet_boot: assert property (!addr_ready |-> !sda_oe && state == ST_IDLE)
    else $error("target active before address set");
  chk_addr_ack: assert property (rx_done && state == ST_ADDR && addr_match |=> sda_oe)
    else $error("matching address not acknowledged");
  chk_addr_miss: assert property (rx_done && state == ST_ADDR && !addr_match
    |=> !sda_oe && state == ST_SKIP)
    else $error("foreign address acknowledged");
  chk_strap_sample: assert property ($rose(addr_ready)
    |-> strap_hi == $past(addr_strap_high_bit) && strap_lo == $past(addr_strap_low_bit))
    else $error("strap levels not captured at boot");
  chk_strap_hold: assert property (addr_ready ##1 addr_ready |-> $stable({strap_hi, strap_lo}))
    else $error("strap latch changed after boot");
  chk_sub_pointer: assert property (ack_end && state == ST_SUB |=> ptr == $past(shreg))
    else $error("sub-address not loaded into pointer");
  chk_stretch_free: assert property (s_byte_end ##0 (!core_busy && load_cnt == 2'h0)
    |=> !scl_oe)
    else $error("clock held after core became ready");
  chk_fetch_bit: assert property (s_fetch |=> sda_oe == !$past(mem_rdata[7]))
    else $error("first read bit not driven after fetch");
  chk_irq_masked: assert property ((irq_event & irq_mask) != 8'h00 |=> !host_interrupt_n)
    else $error("enabled event did not raise interrupt");
  chk_irq_quiet: assert property (!host_interrupt_n |-> (pend & $past(irq_mask)) != 8'h00)
    else $error("interrupt raised for masked event");
endmodule : i2cas_target
`default_nettype wire

// ### verification/i2cas_ctrl.sv
// Controller model on the far side of the target bus
`timescale 1ns/1ps
`default_nettype none
module i2cas_ctrl #(
  // Bus runs faster than fast mode so the run stays short
  parameter int HALF = 100
) (
  // Clock
  input wire logic mclk,
  // Wired bus levels and our pull-downs, low drives
  input wire logic scl,
  input wire logic sda,
  output logic scl_m,
  output logic sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge mclk);
  endtask : hw
  // Target may stretch, so wait for the real line level
  task automatic rise;
    int k;
    k = 0;
    scl_m <= 1'b1;
    hw(1);
    while (scl !== 1'b1 && k < 20000) begin
      hw(1);
      k++;
    end
    hw(HALF / 2);
  endtask : rise
  task automatic bitx(input logic b, output logic r);
    hw(HALF / 4);
    sda_m <= b;
    hw(HALF);
    rise();
    r = sda;
    hw(HALF / 2);
    scl_m <= 1'b0;
  endtask : bitx
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ma, a);
  endtask : xfer
  task automatic start;
    sda_m <= 1'b1;
    hw(HALF / 4);
    rise();
    sda_m <= 1'b0;
    hw(HALF);
    scl_m <= 1'b0;
  endtask : start
  task automatic stop;
    hw(HALF / 4);
    sda_m <= 1'b0;
    hw(HALF);
    rise();
    sda_m <= 1'b1;
    hw(HALF);
  endtask : stop
endmodule : i2cas_ctrl
`default_nettype wire

// ### verification/tb_i2c_target_address_select.sv
// Self-checking bench for the strap-addressed I2C target
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_target_address_select;
  import i2cas_pkg::*;
  logic mclk, rst_b, strap_lo, strap_hi, core_busy, scl_oe, sda_oe, cmd_valid, addr_ready;
  logic irq_n, scl_m, sda_m, scl_out, sda_out, core_wr_en;
  logic [7:0] cmd_addr, cmd_data, irq_event, irq_mask, irq_clear, pend, ptr, core_addr, core_wdata;
  logic [7:0] mem [256];
  logic [7:0] qa[$], qd[$], ea[$], ed[$];
  logic [6:0] a;
  logic [31:0] seed = 32'h0281;
  int errors = 0;
  int n_tests = 0;
  wire logic scl = scl_m & ~scl_oe;
  wire logic sda = sda_m & ~sda_oe;
  i2cas_target dut (.mclk(mclk), .rst_b(rst_b), .addr_strap_low_bit(strap_lo),
    .addr_strap_high_bit(strap_hi), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .core_busy(core_busy),
    .core_wr_en(core_wr_en), .core_addr(core_addr), .core_wdata(core_wdata),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .addr_ready(addr_ready), .irq_event(irq_event), .irq_mask(irq_mask),
    .irq_clear(irq_clear), .host_interrupt_n(irq_n));
  i2cas_ctrl ctl (.mclk(mclk), .scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (cmd_valid === 1'b1) begin
      qa.push_back(cmd_addr);
      qd.push_back(cmd_data);
    end
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic boot(input logic [1:0] s);
    rst_b <= 1'b0;
    strap_lo <= s[0];
    strap_hi <= s[1];
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
  endtask : boot
  task automatic wtx(input logic [6:0] ad, input logic [7:0] sub, input int n, input logic ek);
    logic [7:0] q, d;
    logic k;
    ctl.start();
    ctl.xfer({ad, 1'b0}, 1'b1, q, k);
    chk(ek, k);
    if (k === 1'b0) begin
      ctl.xfer(sub, 1'b1, q, k);
      chk(0, k);
      ptr = sub;
      for (int i = 0; i < n; i++) begin
        d = rnd();
        ctl.xfer(d, 1'b1, q, k);
        chk(0, k);
        mem[ptr] = d;
        ea.push_back(ptr);
        ed.push_back(d);
        ptr++;
      end
    end
    ctl.stop();
    chk(ea.size(), qa.size());
    while (ea.size() > 0 && qa.size() > 0) begin
      chk(ea.pop_front(), qa.pop_front());
      chk(ed.pop_front(), qd.pop_front());
    end
    ea.delete();
    ed.delete();
    qa.delete();
    qd.delete();
  endtask : wtx
  task automatic rtx(input logic [6:0] ad, input logic [7:0] sub, input int n);
    logic [7:0] q;
    logic k;
    ctl.start();
    ctl.xfer({ad, 1'b0}, 1'b1, q, k);
    ctl.xfer(sub, 1'b1, q, k);
    ptr = sub;
    ctl.start();
    ctl.xfer({ad, 1'b1}, 1'b1, q, k);
    chk(0, k);
    for (int i = 0; i < n; i++) begin
      ctl.xfer(8'hFF, i == n - 1, q, k);
      chk(mem[ptr], q);
      ptr++;
    end
    ctl.stop();
  endtask : rtx
  initial begin
    rst_b = 1'b0;
    strap_lo = 1'b0;
    strap_hi = 1'b0;
    core_busy = 1'b0;
    core_wr_en = 1'b0;
    core_addr = 8'h00;
    core_wdata = 8'h00;
    irq_event = 8'h00;
    irq_mask = 8'h00;
    irq_clear = 8'h00;
    pend = 8'h00;
    boot(2'b00);
    chk(0, addr_ready);
    wtx(7'h27, 8'h00, 1, 1'b1);
    chk(1, addr_ready);
    $display("boot test done");
    for (int i = 0; i < 8; i++) begin
      irq_event <= rnd();
      irq_mask <= rnd();
      @(posedge mclk);
      pend = pend | irq_event;
      irq_event <= 8'h00;
      repeat (3) @(posedge mclk);
      chk(~|(pend & irq_mask), irq_n);
      irq_clear <= rnd();
      @(posedge mclk);
      pend = pend & ~irq_clear;
      irq_clear <= 8'h00;
      repeat (3) @(posedge mclk);
      chk(~|(pend & irq_mask), irq_n);
    end
    $display("interrupt test done");
    for (int i = 0; i < 4; i++) begin
      boot(i[1:0]);
      repeat (BOOT_CYC + 4) @(posedge mclk);
      chk(1, addr_ready);
      a = {2'b01, i[1], i[0], 3'b111};
      // Straps move after boot; the address must not follow them
      strap_lo <= ~strap_lo;
      strap_hi <= ~strap_hi;
      wtx(a, rnd(), 1, 1'b0);
      wtx(a ^ 7'h18, 8'h00, 0, 1'b1);
      $display("strap test %0d done", i);
    end
    core_busy <= 1'b1;
    fork
      wtx(a, 8'hFE, 3, 1'b0);
      begin
        repeat (3000) @(posedge mclk);
        chk(1, scl_oe);
        core_busy <= 1'b0;
      end
    join
    rtx(a, 8'hFE, 3);
    // Core side writes one byte to the store at 0x10, the controller reads it back
    core_addr <= 8'h10;
    core_wdata <= rnd();
    core_wr_en <= 1'b1;
    @(posedge mclk);
    mem[core_addr] = core_wdata;
    core_wr_en <= 1'b0;
    rtx(a, 8'h10, 1);
    chk(0, {scl_out, sda_out});
    $display("stretch and read test done");
    test_done();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    test_done();
  end
endmodule : tb_i2c_target_address_select
`default_nettype wire
